// ### hw/dtt_pkg.sv
// Shared constants for the debug trigger and trace status block.
// Assumes a plain register port with one-cycle strobes on sys_clk.
package dtt_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam logic [3:0]  OFF_TRIG_CTRL   = 4'h0;
  localparam logic [3:0]  OFF_TRACE_STAT  = 4'h1;
  localparam logic [3:0]  OFF_DEBUG_CTRL  = 4'h2;
  localparam int          TC_XQUAL_BIT    = 7;
  localparam int          TC_BEGIN_BIT    = 6;
  localparam logic [7:0]  TC_WRITE_MASK   = 8'hcf;
  localparam logic [7:0]  TC_RESET        = 8'h00;
  localparam int          DC_ENABLE_BIT   = 7;
  localparam int          DC_RUN_BIT      = 6;
  localparam int          DC_BRKEN_BIT    = 4;
  localparam logic [7:0]  DC_RESET        = 8'h00;
  localparam logic [3:0]  FIFO_DEPTH      = 4'h8;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

  typedef enum logic [3:0] {
    DTT_MODE_A_ONLY     = 4'b0000,
    DTT_MODE_A_OR_B     = 4'b0001,
    DTT_MODE_A_THEN_B   = 4'b0010,
    DTT_MODE_EVENT_B    = 4'b0011,
    DTT_MODE_A_EVENT_B  = 4'b0100,
    DTT_MODE_A_AND_B    = 4'b0101,
    DTT_MODE_A_NAND_B   = 4'b0110,
    DTT_MODE_INSIDE     = 4'b0111,
    DTT_MODE_OUTSIDE    = 4'b1000
  } dtt_mode_t;

  typedef enum logic [1:0] {
    DTT_IDLE    = 2'b00,
    DTT_ARMED   = 2'b01,
    DTT_STORING = 2'b10
  } dtt_state_t;
endpackage

// ### hw/dtt_core.sv
// Trigger configuration, run sequencing and trace status of the bus debug unit.
// Assumes comparator, opcode tracking and FIFO logic run on sys_clk beside it.
`timescale 1ns/10ps
//Contract
// RQ1: Trigger control writable only while not armed.
// RQ2: Trigger control bits 4 and 5 read zero.
// RQ3: Bit 7 picks force or executed-opcode trigger.
// RQ4: Bit 6 picks end or begin trace.
// RQ5: Event-only modes always run as begin trace.
// RQ6: Modes 0-2: A, A or B, A then B.
// RQ7: Modes 3-4 store on B events.
// RQ8: Modes 5-6: address A with data B match/mismatch.
// RQ9: Modes 7-8: inside or outside address range.
// RQ10: Modes 9 through 15 never trigger.
// RQ11: Trace status is read-only.
// RQ12: A flag clears at start, sets on A.
// RQ13: B flag clears at start, sets on B.
// RQ14: Armed status bit mirrors run request when enabled.
// RQ15: Armed on run write, clears at run end.
// RQ16: Begin ends on full, end ends on trigger.
// RQ17: Writing zero to run or enable ends run.
// RQ18: Count clears at start, reports words stored.
// RQ19: Count never decrements on FIFO reads.
// RQ20: Enable cannot be set while secured.
// RQ21: Breaks on full or trigger when enabled.
// RQ22: Count increments per stored word, saturates eight.
module dtt_core
  import dtt_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic [dtt_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [dtt_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [dtt_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                 mcu_secure,
  input  wire logic                 cmp_a_match,
  input  wire logic                 cmp_b_match,
  input  wire logic                 cmp_b_data_match,
  input  wire logic                 addr_below_a,
  input  wire logic                 addr_above_b,
  input  wire logic                 opcode_exec_a,
  input  wire logic                 opcode_exec_b,
  input  wire logic                 fifo_full,
  input  wire logic                 fifo_push,
  output logic                      run_active,
  output logic                      store_enable,
  output logic                      event_only,
  output logic                      trigger_pulse,
  output logic                      break_request
);
  import dtt_pkg::*;

  logic [7:0]  trig_ctrl_q;
  logic [7:0]  dbg_ctrl_q;
  logic        a_hit_q;
  logic        b_hit_q;
  logic        a_seen_q;
  logic [3:0]  count_q;
  dtt_state_t  state_q;
  logic        arm_prev_q;
  logic        wr_tc;
  logic        wr_dc;
  logic        run_start;
  logic        run_end;
  logic        manual_stop;
  logic        a_qual;
  logic        b_qual;
  logic        trig;
  logic        store_ev;
  logic        begin_trace;
  logic [3:0]  mode;
  logic        enable;
  logic        armed;

  function automatic logic is_event_mode(input logic [3:0] m);
    return (m == DTT_MODE_EVENT_B) || (m == DTT_MODE_A_EVENT_B);
  endfunction

  assign mode   = trig_ctrl_q[3:0];
  assign enable = dbg_ctrl_q[DC_ENABLE_BIT];
  assign armed  = dbg_ctrl_q[DC_RUN_BIT];
  assign wr_tc  = reg_wr && (reg_addr == OFF_TRIG_CTRL);
  assign wr_dc  = reg_wr && (reg_addr == OFF_DEBUG_CTRL);

  // Tag type routes the A and B comparator matches through the opcode execution tracker; the data match and range inputs bypass it.
  assign a_qual = trig_ctrl_q[TC_XQUAL_BIT] ? opcode_exec_a : cmp_a_match; // RQ3
  assign b_qual = trig_ctrl_q[TC_XQUAL_BIT] ? opcode_exec_b : cmp_b_match; // RQ3

  assign begin_trace = trig_ctrl_q[TC_BEGIN_BIT] || is_event_mode(mode); // RQ4 RQ5
  assign event_only  = is_event_mode(mode); // RQ5

  // Decodes the trigger condition for the selected mode.
  always_comb begin
    trig     = 1'b0;
    store_ev = 1'b0;
    case (mode)
      DTT_MODE_A_ONLY:    trig = a_qual; // RQ6
      DTT_MODE_A_OR_B:    trig = a_qual || b_qual; // RQ6
      DTT_MODE_A_THEN_B:  trig = a_seen_q && b_qual; // RQ6
      DTT_MODE_EVENT_B: begin
        trig     = b_qual; // RQ7
        store_ev = b_qual; // RQ7
      end
      DTT_MODE_A_EVENT_B: begin
        trig     = a_seen_q && b_qual; // RQ7
        store_ev = a_seen_q && b_qual; // RQ7
      end
      DTT_MODE_A_AND_B:   trig = a_qual && cmp_b_data_match; // RQ8
      DTT_MODE_A_NAND_B:  trig = a_qual && !cmp_b_data_match; // RQ8
      DTT_MODE_INSIDE:    trig = !addr_below_a && !addr_above_b; // RQ9
      DTT_MODE_OUTSIDE:   trig = addr_below_a || addr_above_b; // RQ9
      default:            trig = 1'b0; // RQ10
    endcase
  end

  assign trigger_pulse = armed && trig;
  assign manual_stop   = wr_dc && (!reg_wdata[DC_RUN_BIT] || !reg_wdata[DC_ENABLE_BIT]); // RQ17
  assign run_start     = armed && !arm_prev_q;
  assign run_end       = armed && (begin_trace ? fifo_full : trigger_pulse); // RQ16

  // Debug control: run request set by software, cleared at run end.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dbg_ctrl_q <= DC_RESET;
    end else if (wr_dc) begin
      dbg_ctrl_q <= reg_wdata;
      if (mcu_secure && !enable) begin
        dbg_ctrl_q[DC_ENABLE_BIT] <= 1'b0; // RQ20
      end
      if (!(reg_wdata[DC_ENABLE_BIT] && (enable || !mcu_secure))) begin
        dbg_ctrl_q[DC_RUN_BIT] <= 1'b0; // RQ15 RQ17
      end
    end else if (run_end) begin
      dbg_ctrl_q[DC_RUN_BIT] <= 1'b0; // RQ15 RQ16
    end
  end

  // Trigger control: locked while armed, bits 4 and 5 kept zero.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      trig_ctrl_q <= TC_RESET;
    end else if (wr_tc && !armed) begin // RQ1
      trig_ctrl_q <= reg_wdata & TC_WRITE_MASK; // RQ2
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      arm_prev_q <= 1'b0;
    end else begin
      arm_prev_q <= armed;
    end
  end

  // Match flags; a match in the first armed cycle wins over the start clear.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      a_hit_q <= 1'b0;
      b_hit_q <= 1'b0;
    end else if (run_start) begin
      a_hit_q <= a_qual; // RQ12
      b_hit_q <= b_qual; // RQ13
    end else if (armed) begin
      if (a_qual) begin
        a_hit_q <= 1'b1; // RQ12
      end
      if (b_qual) begin
        b_hit_q <= 1'b1; // RQ13
      end
    end
  end

  // A-seen sequencer: wiped while idle, so no run inherits an old A match.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      a_seen_q <= 1'b0;
    end else if (!armed) begin
      a_seen_q <= 1'b0;
    end else if (a_qual) begin
      a_seen_q <= 1'b1; // RQ6 RQ7
    end
  end

  // Run state: begin traces wait for trigger before storing.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= DTT_IDLE;
    end else begin
      case (state_q)
        DTT_IDLE: begin
          if (armed && !manual_stop) begin
            state_q <= (begin_trace && !event_only && !trigger_pulse) ? DTT_ARMED : DTT_STORING; // RQ4
          end
        end
        DTT_ARMED: begin
          if (!armed || manual_stop) begin
            state_q <= DTT_IDLE;
          end else if (trigger_pulse) begin
            state_q <= DTT_STORING; // RQ4
          end
        end
        DTT_STORING: begin
          if (!armed || run_end || manual_stop) begin
            state_q <= DTT_IDLE;
          end
        end
        default: state_q <= DTT_IDLE;
      endcase
    end
  end

  assign store_enable = (state_q == DTT_STORING) && armed &&
                        (!event_only || store_ev); // RQ7
  assign run_active   = armed;

  // Valid count: cleared at start, counts pushes, saturates; reads never touch it.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count_q <= 4'h0;
    end else if (run_start) begin
      count_q <= 4'h0; // RQ18
    end else if (armed && fifo_push && (count_q != FIFO_DEPTH)) begin
      count_q <= count_q + 4'h1; // RQ22 RQ19
    end
  end

  // Break request on the run-ending event when breaks are enabled.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      break_request <= 1'b0;
    end else begin
      break_request <= dbg_ctrl_q[DC_BRKEN_BIT] && run_end; // RQ21
    end
  end

  // Register read port; trace status ignores writes entirely.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_TRIG_CTRL:  reg_rdata <= trig_ctrl_q & TC_WRITE_MASK; // RQ2
        OFF_TRACE_STAT: reg_rdata <= {a_hit_q, b_hit_q, enable && armed, 1'b0,
                                      count_q}; // RQ11 RQ14 RQ18
        OFF_DEBUG_CTRL: reg_rdata <= dbg_ctrl_q;
        default:        reg_rdata <= UNMAPPED_READ;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  property p_tc_locked;
    @(posedge sys_clk) disable iff (!rst_b)
      armed && !$past(wr_dc) |=> $stable(trig_ctrl_q) || !$past(armed);
  endproperty
  a_tc_locked: assert property (p_tc_locked) else $error("Trigger control changed while armed."); // RQ1

  property p_tc_zero;
    @(posedge sys_clk) disable iff (!rst_b) trig_ctrl_q[5:4] == 2'b00;
  endproperty
  a_tc_zero: assert property (p_tc_zero) else $error("Hard-wired trigger bits set."); // RQ2

  property p_no_trig_high;
    @(posedge sys_clk) disable iff (!rst_b) mode > 4'h8 |-> !trigger_pulse;
  endproperty
  a_no_trig_high: assert property (p_no_trig_high) else $error("Reserved mode triggered."); // RQ10

  property p_flags_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      run_start && !a_qual && !b_qual |=> !a_hit_q && !b_hit_q;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("Match flags not cleared at start."); // RQ12

  property p_b_flag;
    @(posedge sys_clk) disable iff (!rst_b) armed && !run_start && b_qual |=> b_hit_q;
  endproperty
  a_b_flag: assert property (p_b_flag) else $error("B flag not set on match."); // RQ13

  property p_end_trace_stop;
    @(posedge sys_clk) disable iff (!rst_b)
      armed && !begin_trace && trigger_pulse && !wr_dc |=> !armed;
  endproperty
  a_end_trace_stop: assert property (p_end_trace_stop) else $error("End trace kept running."); // RQ16

  property p_manual_stop;
    @(posedge sys_clk) disable iff (!rst_b) manual_stop |=> !armed;
  endproperty
  a_manual_stop: assert property (p_manual_stop) else $error("Run survived a stop write."); // RQ17

  property p_secure;
    @(posedge sys_clk) disable iff (!rst_b) mcu_secure && !enable |=> !enable;
  endproperty
  a_secure: assert property (p_secure) else $error("Enable set while secured."); // RQ20

  property p_count_sat;
    @(posedge sys_clk) disable iff (!rst_b) count_q <= FIFO_DEPTH;
  endproperty
  a_count_sat: assert property (p_count_sat) else $error("Valid count passed eight."); // RQ22

  property p_count_start;
    @(posedge sys_clk) disable iff (!rst_b) run_start |=> count_q == 4'h0;
  endproperty
  a_count_start: assert property (p_count_start) else $error("Count not cleared at start."); // RQ18

  property p_tc_write;
    @(posedge sys_clk) disable iff (!rst_b)
      wr_tc && !armed |=> trig_ctrl_q == ($past(reg_wdata) & TC_WRITE_MASK);
  endproperty
  a_tc_write: assert property (p_tc_write) else $error("Idle trigger write lost."); // RQ1

  property p_rd_zero;
    @(posedge sys_clk) disable iff (!rst_b)
      reg_rd && (reg_addr == OFF_TRIG_CTRL) |=> reg_rdata[5:4] == 2'b00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("Hard-wired bits read as one."); // RQ2

  property p_force;
    @(posedge sys_clk) disable iff (!rst_b)
      !trig_ctrl_q[TC_XQUAL_BIT] && (mode == DTT_MODE_A_ONLY) && armed && cmp_a_match |-> trigger_pulse;
  endproperty
  a_force: assert property (p_force) else $error("Force match did not trigger."); // RQ3

  property p_event_run;
    @(posedge sys_clk) disable iff (!rst_b)
      armed && event_only && !fifo_full && !wr_dc |=> armed;
  endproperty
  a_event_run: assert property (p_event_run) else $error("Event run ended before full."); // RQ5

  property p_a_then_b;
    @(posedge sys_clk) disable iff (!rst_b)
      (mode == DTT_MODE_A_THEN_B) && !a_seen_q |-> !trigger_pulse;
  endproperty
  a_a_then_b: assert property (p_a_then_b) else $error("B triggered before A."); // RQ6

  property p_event_store;
    @(posedge sys_clk) disable iff (!rst_b)
      event_only && store_enable |-> b_qual;
  endproperty
  a_event_store: assert property (p_event_store) else $error("Event store without B."); // RQ7

  property p_full_mode;
    @(posedge sys_clk) disable iff (!rst_b)
      armed && (mode == DTT_MODE_A_AND_B) && a_qual && cmp_b_data_match |-> trigger_pulse;
  endproperty
  a_full_mode: assert property (p_full_mode) else $error("Full mode missed."); // RQ8

  property p_a_flag;
    @(posedge sys_clk) disable iff (!rst_b)
      armed && a_qual |=> a_hit_q;
  endproperty
  a_a_flag: assert property (p_a_flag) else $error("A flag not set on match."); // RQ12

  property p_stat_mirror;
    @(posedge sys_clk) disable iff (!rst_b)
      reg_rd && (reg_addr == OFF_TRACE_STAT) && enable |=> reg_rdata[5] == $past(armed);
  endproperty
  a_stat_mirror: assert property (p_stat_mirror) else $error("Armed image wrong."); // RQ14

  property p_arm_set;
    @(posedge sys_clk) disable iff (!rst_b)
      wr_dc && reg_wdata[DC_RUN_BIT] && reg_wdata[DC_ENABLE_BIT] && (enable || !mcu_secure) |=> armed;
  endproperty
  a_arm_set: assert property (p_arm_set) else $error("Run write did not arm."); // RQ15

  property p_begin_full;
    @(posedge sys_clk) disable iff (!rst_b)
      armed && begin_trace && fifo_full && !wr_dc |=> !armed;
  endproperty
  a_begin_full: assert property (p_begin_full) else $error("Begin trace ran past full."); // RQ16

  property p_count_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      !armed |=> $stable(count_q);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("Count moved while idle."); // RQ19

  property p_count_inc;
    @(posedge sys_clk) disable iff (!rst_b)
      armed && fifo_push && (count_q != FIFO_DEPTH) && !run_start |=>
      count_q == $past(count_q) + 4'h1;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("Count missed a stored word."); // RQ22

  property p_break;
    @(posedge sys_clk) disable iff (!rst_b)
      dbg_ctrl_q[DC_BRKEN_BIT] && run_end |=> break_request;
  endproperty
  a_break: assert property (p_break) else $error("Break not requested at run end."); // RQ21
endmodule

// ### verif/dtt_fifo_model.sv
// Stand-in for the trace FIFO that sits beside the debug block.
// Assumes store_enable comes from the block on sys_clk; feed is set by the bench.
`timescale 1ns/10ps
module dtt_fifo_model (
  input  wire logic sys_clk,
  input  wire logic feed,
  input  wire logic store_enable,
  output logic      fifo_push,
  output logic      fifo_full
);
  logic [3:0] fill_q;
  // A word is offered each cycle while fed, and refused once eight are held.
  assign fifo_push = feed & store_enable & ~fifo_full;
  assign fifo_full = (fill_q == 4'h8);
  always_ff @(posedge sys_clk) begin
    if (!feed) begin
      fill_q <= 4'h0;
    end else if (fifo_push) begin
      fill_q <= fill_q + 4'h1;
    end
  end
endmodule

// ### verif/dtt_core_bench.sv
// Self-checking bench for the debug trigger and trace status block.
// Assumes the FIFO stand-in model; the bench acts as the register host.
`timescale 1ns/10ps
module dtt_core_bench;
  import dtt_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       sec = 1'b0, xa = 1'b0, xb = 1'b0, feed = 1'b0;
  logic       a = 1'b0, b = 1'b0, bd = 1'b0, bl = 1'b0, ab = 1'b0;
  logic       push, full, run, stor, evo, trig, brk;
  logic       brk_seen = 1'b0;
  int         fails = 0, n_checks = 0, cyc = 0;
  logic [3:0] md [9] = '{4'h0, 4'h1, 4'h5, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hf};
  logic [4:0] st [9] = '{5'h10, 5'h08, 5'h14, 5'h10, 5'h10, 5'h00, 5'h02, 5'h1f, 5'h1f};
  logic [0:8] ex = 9'b111011100;

  dtt_core dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mcu_secure(sec), .cmp_a_match(a), .cmp_b_match(b), .cmp_b_data_match(bd),
    .addr_below_a(bl), .addr_above_b(ab), .opcode_exec_a(xa), .opcode_exec_b(xb),
    .fifo_full(full), .fifo_push(push), .run_active(run), .store_enable(stor),
    .event_only(evo), .trigger_pulse(trig), .break_request(brk));
  dtt_fifo_model fifo_u (.sys_clk(sys_clk), .feed(feed), .store_enable(stor),
    .fifo_push(push), .fifo_full(full));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (brk === 1'b1) brk_seen = 1'b1;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask

  task automatic t_regs;
    rd(OFF_TRIG_CTRL, 8'h00, "trig reset");
    rd(OFF_TRACE_STAT, 8'h00, "stat reset");
    rd(4'h3, UNMAPPED_READ, "unmapped");
    wr(OFF_TRIG_CTRL, 8'hff);
    rd(OFF_TRIG_CTRL, 8'hcf, "trig mask");
    wr(OFF_DEBUG_CTRL, 8'hc0);
    wr(OFF_TRIG_CTRL, 8'h00);
    rd(OFF_TRIG_CTRL, 8'hcf, "trig armed");
    wr(OFF_TRACE_STAT, 8'h00);
    rd(OFF_TRACE_STAT, 8'h20, "stat armed");
    wr(OFF_DEBUG_CTRL, 8'h80);
    chk("run stop", 8'h00, {7'h0, run});
    $display("test regs done");
  endtask
  task automatic t_modes;
    for (int i = 0; i < 9; i++) begin
      @(posedge sys_clk);
      {a, b, bd, bl, ab} <= st[i];
      wr(OFF_TRIG_CTRL, {4'h0, md[i]});
      wr(OFF_DEBUG_CTRL, 8'hc0);
      chk("trigger", {7'h0, ex[i]}, {7'h0, trig});
      @(posedge sys_clk);
      {a, b, bd, bl, ab} <= 5'h00;
      wr(OFF_DEBUG_CTRL, 8'h80);
    end
    wr(OFF_TRIG_CTRL, 8'h03);
    wr(OFF_DEBUG_CTRL, 8'hc0);
    @(posedge sys_clk);
    #1 chk("event idle", 8'h02, {6'h0, evo, stor});
    @(posedge sys_clk);
    b <= 1'b1;
    #1 chk("event store", 8'h03, {6'h0, evo, stor});
    @(posedge sys_clk);
    b <= 1'b0;
    wr(OFF_DEBUG_CTRL, 8'h80);
    wr(OFF_TRIG_CTRL, 8'h02);
    wr(OFF_DEBUG_CTRL, 8'hc0);
    @(posedge sys_clk);
    b <= 1'b1;
    #1 chk("b before a", 8'h00, {7'h0, trig});
    @(posedge sys_clk);
    b <= 1'b0;
    a <= 1'b1;
    #1 chk("a first", 8'h00, {7'h0, trig});
    @(posedge sys_clk);
    a <= 1'b0;
    b <= 1'b1;
    #1 chk("a then b", 8'h01, {7'h0, trig});
    @(posedge sys_clk);
    b <= 1'b0;
    #1 chk("a then b end", 8'h00, {7'h0, run});
    wr(OFF_TRIG_CTRL, 8'h04);
    wr(OFF_DEBUG_CTRL, 8'hc0);
    @(posedge sys_clk);
    b <= 1'b1;
    #1 chk("event b early", 8'h02, {6'h0, evo, stor});
    @(posedge sys_clk);
    b <= 1'b0;
    a <= 1'b1;
    @(posedge sys_clk);
    a <= 1'b0;
    b <= 1'b1;
    #1 chk("a then event b", 8'h03, {6'h0, evo, stor});
    @(posedge sys_clk);
    b <= 1'b0;
    wr(OFF_DEBUG_CTRL, 8'h80);
    $display("test modes done");
  endtask
  task automatic t_tag;
    wr(OFF_TRIG_CTRL, 8'h80);
    wr(OFF_DEBUG_CTRL, 8'hc0);
    @(posedge sys_clk);
    a <= 1'b1;
    #1 chk("tag no exec", 8'h00, {7'h0, trig});
    @(posedge sys_clk);
    xa <= 1'b1;
    #1 chk("tag exec", 8'h01, {7'h0, trig});
    @(posedge sys_clk);
    a <= 1'b0;
    xa <= 1'b0;
    #1 chk("tag end", 8'h00, {7'h0, run});
    wr(OFF_TRIG_CTRL, 8'h81);
    wr(OFF_DEBUG_CTRL, 8'hc0);
    @(posedge sys_clk);
    b <= 1'b1;
    #1 chk("tag b no exec", 8'h00, {7'h0, trig});
    @(posedge sys_clk);
    xb <= 1'b1;
    #1 chk("tag b exec", 8'h01, {7'h0, trig});
    @(posedge sys_clk);
    b <= 1'b0;
    xb <= 1'b0;
    $display("test tag done");
  endtask
  task automatic t_runs;
    chk("no break yet", 8'h00, {7'h0, brk_seen});
    wr(OFF_TRIG_CTRL, 8'h40);
    wr(OFF_DEBUG_CTRL, 8'hd0);
    @(posedge sys_clk);
    feed <= 1'b1;
    a <= 1'b1;
    #1 chk("begin wait", 8'h00, {7'h0, stor});
    @(posedge sys_clk);
    a <= 1'b0;
    #1 chk("begin store", 8'h01, {7'h0, stor});
    repeat (14) @(posedge sys_clk);
    feed <= 1'b0;
    rd(OFF_TRACE_STAT, 8'h88, "begin stat");
    chk("break", 8'h01, {7'h0, brk_seen});
    wr(OFF_TRIG_CTRL, 8'h00);
    wr(OFF_DEBUG_CTRL, 8'hc0);
    rd(OFF_TRACE_STAT, 8'h20, "start clear");
    @(posedge sys_clk);
    feed <= 1'b1;
    repeat (3) @(posedge sys_clk);
    feed <= 1'b0;
    b <= 1'b1;
    @(posedge sys_clk);
    b <= 1'b0;
    a <= 1'b1;
    @(posedge sys_clk);
    a <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(OFF_TRACE_STAT, 8'hc3, "end stat");
    rd(OFF_TRACE_STAT, 8'hc3, "no decrement");
    @(posedge sys_clk);
    sec <= 1'b1;
    wr(OFF_DEBUG_CTRL, 8'h00);
    wr(OFF_DEBUG_CTRL, 8'hc0);
    chk("secure", 8'h00, {7'h0, run});
    rd(OFF_DEBUG_CTRL, 8'h00, "secure enable");
    @(posedge sys_clk);
    sec <= 1'b0;
    wr(OFF_DEBUG_CTRL, 8'hc0);
    wr(OFF_DEBUG_CTRL, 8'h40);
    chk("enable stop", 8'h00, {7'h0, run});
    $display("test runs done");
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_modes();
    t_tag();
    t_runs();
    test_done();
  end
endmodule
